/* File: fiber_aneg_map.svh */
`ifndef FIBER_ANEG_MAP_SVH
`define FIBER_ANEG_MAP_SVH

// Register offsets, word index on the plain port
`define ADVERT_OFFSET        4'h4
`define CTRL_OFFSET          4'h0
`define IRQ_STATUS_OFFSET    4'h1
`define IRQ_MASK_OFFSET      4'h2

// Advertisement field positions
`define HALF_DUPLEX_BIT      6
`define FULL_DUPLEX_BIT      5
`define HALF_STRAP_BIT       2
`define FULL_STRAP_BIT       3

// Copper status view fields
`define CU_LINK_BIT          15
`define CU_DUPLEX_BIT        12
`define CU_SPEED_LSB         10

// Partner ability view fields
`define LP_PAUSE_LSB         7
`define LP_HALF_BIT          6
`define LP_FULL_BIT          5

// Control register fields
`define CTRL_SW_RESET_BIT    15
`define CTRL_RESTART_BIT     9
`define CTRL_POWER_DOWN_BIT  11

// Hardware configuration mode codes
`define MODE_SGMII_COPPER    4'h0
`define MODE_GBIC            4'h8
`define MODE_SGMII_RGMII_LOW 3'h6

// Reset values
`define ADVERT_RESET         2'h0
`define CTRL_RESET           16'h0000
`define IRQ_RESET            4'h0

`endif

/* File: fiber_aneg_pkg.sv */
package fiber_aneg_pkg;

  // Layout presented at the advertisement address
  typedef enum logic [3:0] {
    LAYOUT_FIBER    = 4'h1,
    LAYOUT_SGMII_CU = 4'h2,
    LAYOUT_RSVD     = 4'h4,
    LAYOUT_GBIC     = 4'h8
  } layout_t;

  // Register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // Copper side status
  typedef struct packed {
    logic       link_up;
    logic       full_duplex;
    logic [1:0] speed;
    logic [1:0] lp_pause;
    logic       lp_half;
    logic       lp_full;
  } copper_status_t;

  // Events that commit a pending write
  typedef struct packed {
    logic sw_reset;
    logic restart;
    logic power_up;
    logic link_down;
  } commit_ev_t;

endpackage

/* File: pin_sync.sv */
`include "fiber_aneg_map.svh"

// Two-stage synchroniser per bit
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // pin_sync

/* File: layout_select.sv */
`include "fiber_aneg_map.svh"

// Maps the hardware configuration mode to a register layout
module layout_select
  import fiber_aneg_pkg::*;
(
  input  wire logic [3:0] clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] mode_in,
  output layout_t         layout_out
);

  layout_t layout_next;

  // Reserved layout wins for x110, then exact codes
  always_comb begin
    if (mode_in[2:0] == `MODE_SGMII_RGMII_LOW) begin
      layout_next = LAYOUT_RSVD;
    end else if (mode_in == `MODE_SGMII_COPPER) begin
      layout_next = LAYOUT_SGMII_CU;
    end else if (mode_in == `MODE_GBIC) begin
      layout_next = LAYOUT_GBIC;
    end else begin
      layout_next = LAYOUT_FIBER;
    end
  end

  // Registered so reads see a stable layout
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      layout_out <= LAYOUT_FIBER;
    end else begin
      layout_out <= layout_next;
    end
  end

endmodule // layout_select

/* File: fiber_aneg_advert.sv */
// Behaviour
// - Fiber mode: duplex writes wait pending until software reset or restart.
// - Pending write also applies on power-up transition or link going down.
// - Hardware reset loads half from strap bit 2, full from strap bit 3.
// - Both duplex advertisement bits are readable and writable; one advertises.
// - Mode x110: whole register reserved, reads zero, writes ignored.
// - SGMII-to-copper mode: register is a read-only copper status view.
// - Copper view bit 15 shows link up, cleared by both resets.
// - Copper view bit 12 shows resolved duplex, one for full.
// - Copper view bits 11:10 show resolved speed code.
// - GBIC mode: bits 8:7 read-only partner pause ability.
// - GBIC pause field passes the partner encoding unchanged.
// - GBIC bit 6 shows partner half-duplex capability.
// - GBIC bit 5 shows partner full-duplex capability.
`include "fiber_aneg_map.svh"

module fiber_aneg_advert
  import fiber_aneg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [3:0]  autoneg_strap_config_in,
  input  wire logic [3:0]  hw_mode_in,
  input  wire logic        link_up_in,
  input  wire logic        full_duplex_in,
  input  wire logic [1:0]  speed_in,
  input  wire logic [1:0]  lp_pause_in,
  input  wire logic        lp_half_in,
  input  wire logic        lp_full_in,
  output logic      [15:0] rdata_out,
  output logic      [1:0]  advert_out,
  output logic             irq_out
);

  bus_req_t       req;
  copper_status_t cu_raw;
  copper_status_t cu_sync;
  commit_ev_t     ev;
  layout_t        layout;
  logic [3:0]     strap_sync;
  logic [3:0]     mode_sync;
  logic [1:0]     advert_reg;
  logic [1:0]     pend_reg;
  logic           pend_valid_reg;
  logic [15:0]    ctrl_reg;
  logic           link_prev_reg;
  logic           strap_done_reg;
  logic [3:0]     irq_status_reg;
  logic [3:0]     irq_mask_reg;
  logic [3:0]     irq_status_next;
  logic [15:0]    rdata_next;
  logic [15:0]    advert_view;
  logic           ctrl_wr;
  logic           advert_wr;

  assign req    = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign cu_raw = '{link_up: link_up_in, full_duplex: full_duplex_in, speed: speed_in,
                    lp_pause: lp_pause_in, lp_half: lp_half_in, lp_full: lp_full_in};

  // Pins from the copper side cross in
  pin_sync #(.WIDTH(8)) u_cu_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (cu_raw),
    .sync_out (cu_sync)
  );

  // Straps and mode keep syncing through reset, so they are settled at release
  pin_sync #(.WIDTH(8)) u_cfg_sync (
    .clk_in   (clk_in),
    .rst_in   (1'b0),
    .async_in ({autoneg_strap_config_in, hw_mode_in}),
    .sync_out ({strap_sync, mode_sync})
  );

  layout_select u_layout (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .mode_in    (mode_sync),
    .layout_out (layout)
  );

  assign ctrl_wr   = req.wr && (req.addr == `CTRL_OFFSET);
  assign advert_wr = req.wr && (req.addr == `ADVERT_OFFSET);

  // Control register; self-clearing command bits drop after one cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= req.wdata;
    end else begin
      ctrl_reg[`CTRL_SW_RESET_BIT] <= 1'b0;
      ctrl_reg[`CTRL_RESTART_BIT]  <= 1'b0;
    end
  end

  // Commit events decoded from control writes and the link
  always_comb begin
    ev.sw_reset  = ctrl_wr && req.wdata[`CTRL_SW_RESET_BIT];
    ev.restart   = ctrl_wr && req.wdata[`CTRL_RESTART_BIT];
    ev.power_up  = ctrl_wr && ctrl_reg[`CTRL_POWER_DOWN_BIT]
                   && !req.wdata[`CTRL_POWER_DOWN_BIT];
    ev.link_down = link_prev_reg && !cu_sync.link_up;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_prev_reg <= 1'b0;
    end else begin
      link_prev_reg <= cu_sync.link_up;
    end
  end

  // Pending write capture; only the fiber layout accepts it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_reg       <= `ADVERT_RESET;
      pend_valid_reg <= 1'b0;
    end else if (advert_wr && layout == LAYOUT_FIBER) begin
      pend_reg       <= {req.wdata[`HALF_DUPLEX_BIT], req.wdata[`FULL_DUPLEX_BIT]};
      pend_valid_reg <= 1'b1;
    end else if (|ev) begin
      pend_valid_reg <= 1'b0;
    end
  end

  // Active advert; straps loaded once after reset release, kept over soft reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      advert_reg     <= `ADVERT_RESET;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      advert_reg     <= {strap_sync[`HALF_STRAP_BIT], strap_sync[`FULL_STRAP_BIT]};
      strap_done_reg <= 1'b1;
    end else if (pend_valid_reg && (|ev)) begin
      advert_reg <= pend_reg;
    end
  end

  // Read view per layout; reserved bits read zero
  always_comb begin
    advert_view = 16'h0000;
    case (layout)
      LAYOUT_FIBER: begin
        advert_view[`HALF_DUPLEX_BIT] = advert_reg[1];
        advert_view[`FULL_DUPLEX_BIT] = advert_reg[0];
      end
      LAYOUT_SGMII_CU: begin
        advert_view[`CU_LINK_BIT]   = cu_sync.link_up && !ctrl_reg[`CTRL_SW_RESET_BIT];
        advert_view[`CU_DUPLEX_BIT] = cu_sync.full_duplex;
        advert_view[`CU_SPEED_LSB +: 2] = cu_sync.speed;
      end
      LAYOUT_GBIC: begin
        advert_view[`LP_PAUSE_LSB +: 2] = cu_sync.lp_pause;
        advert_view[`LP_HALF_BIT]       = cu_sync.lp_half;
        advert_view[`LP_FULL_BIT]       = cu_sync.lp_full;
      end
      LAYOUT_RSVD: begin
        advert_view = 16'h0000;
      end
      default: begin
        advert_view = 16'h0000;
      end
    endcase
  end

  // Events: bit0 link down, bit1 pending committed, bit2 layout change unused
  always_comb begin
    irq_status_next = irq_status_reg;
    if (req.rd && req.addr == `IRQ_STATUS_OFFSET) begin
      irq_status_next = `IRQ_RESET;
    end
    // Set after clear so a same-cycle event survives
    if (ev.link_down) begin
      irq_status_next[0] = 1'b1;
    end
    if (pend_valid_reg && (|ev)) begin
      irq_status_next[1] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status_reg <= `IRQ_RESET;
      irq_mask_reg   <= `IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
      if (req.wr && req.addr == `IRQ_MASK_OFFSET) begin
        irq_mask_reg <= req.wdata[3:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (req.addr)
      `ADVERT_OFFSET:     rdata_next = advert_view;
      `CTRL_OFFSET:       rdata_next = ctrl_reg;
      `IRQ_STATUS_OFFSET: rdata_next = {12'h000, irq_status_reg};
      `IRQ_MASK_OFFSET:   rdata_next = {12'h000, irq_mask_reg};
      default:            rdata_next = 16'h0000;
    endcase
  end

  // Outputs all registered
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out  <= 16'h0000;
      advert_out <= `ADVERT_RESET;
      irq_out    <= 1'b0;
    end else begin
      rdata_out  <= req.rd ? rdata_next : 16'h0000;
      advert_out <= advert_reg;
      irq_out    <= |(irq_status_next & irq_mask_reg);
    end
  end

  // Assertions
  property p_hold_pending;
    @(posedge clk_in) disable iff (rst_in)
      (strap_done_reg && !(|ev)) |=> (advert_reg == $past(advert_reg));
  endproperty
  a_hold_pending: assert property (p_hold_pending)
    else $error("advert changed without commit event");

  property p_commit;
    @(posedge clk_in) disable iff (rst_in)
      (strap_done_reg && pend_valid_reg && (ev.sw_reset || ev.restart))
        |=> (advert_reg == $past(pend_reg)) ##1 (advert_out == $past(pend_reg, 2));
  endproperty
  a_commit: assert property (p_commit)
    else $error("pending write not committed");

  property p_power_link;
    @(posedge clk_in) disable iff (rst_in)
      (strap_done_reg && pend_valid_reg && (ev.power_up || ev.link_down))
        |=> advert_reg == $past(pend_reg);
  endproperty
  a_power_link: assert property (p_power_link)
    else $error("power-up or link-down commit missed");

  property p_strap;
    @(posedge clk_in) disable iff (rst_in)
      !strap_done_reg |=> advert_reg == {$past(strap_sync[2]), $past(strap_sync[3])};
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap default wrong");

  property p_fiber_read;
    @(posedge clk_in) disable iff (rst_in)
      (req.rd && req.addr == `ADVERT_OFFSET && layout == LAYOUT_FIBER)
        |=> rdata_out == {9'h000, $past(advert_reg), 5'h00};
  endproperty
  a_fiber_read: assert property (p_fiber_read)
    else $error("fiber read wrong");

  property p_rsvd;
    @(posedge clk_in) disable iff (rst_in)
      (req.rd && req.addr == `ADVERT_OFFSET && layout == LAYOUT_RSVD) |=> rdata_out == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved layout not zero");

  property p_copper;
    @(posedge clk_in) disable iff (rst_in)
      (req.rd && req.addr == `ADVERT_OFFSET && layout == LAYOUT_SGMII_CU && !ctrl_reg[15])
        |=> rdata_out == {$past(cu_sync.link_up), 2'b00, $past(cu_sync.full_duplex),
                          $past(cu_sync.speed), 10'h000};
  endproperty
  a_copper: assert property (p_copper)
    else $error("copper view wrong");

  property p_gbic;
    @(posedge clk_in) disable iff (rst_in)
      (req.rd && req.addr == `ADVERT_OFFSET && layout == LAYOUT_GBIC)
        |=> rdata_out == {7'h00, $past(cu_sync.lp_pause), $past(cu_sync.lp_half),
                          $past(cu_sync.lp_full), 5'h00};
  endproperty
  a_gbic: assert property (p_gbic)
    else $error("gbic view wrong");

  property p_ro_views;
    @(posedge clk_in) disable iff (rst_in)
      (advert_wr && layout != LAYOUT_FIBER) |=> pend_reg == $past(pend_reg);
  endproperty
  a_ro_views: assert property (p_ro_views)
    else $error("write accepted in read-only layout");

  property p_soft_keep;
    @(posedge clk_in) disable iff (rst_in)
      (strap_done_reg && ev.sw_reset && !pend_valid_reg) |=> advert_reg == $past(advert_reg);
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("advert lost on software reset");

  property p_copper_clear;
    @(posedge clk_in) disable iff (rst_in)
      (req.rd && req.addr == `ADVERT_OFFSET && layout == LAYOUT_SGMII_CU
        && ctrl_reg[`CTRL_SW_RESET_BIT]) |=> !rdata_out[`CU_LINK_BIT];
  endproperty
  a_copper_clear: assert property (p_copper_clear)
    else $error("copper link bit not cleared by software reset");

  property p_rdata_idle;
    @(posedge clk_in) disable iff (rst_in)
      !req.rd |=> rdata_out == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data stood past its cycle");

  property p_irq_level;
    @(posedge clk_in) disable iff (rst_in)
      !(req.wr && req.addr == `IRQ_MASK_OFFSET)
        |=> irq_out == |(irq_status_reg & irq_mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt line disagrees with status and mask");

  property p_layout_rsvd;
    @(posedge clk_in) disable iff (rst_in)
      (mode_sync[2:0] == `MODE_SGMII_RGMII_LOW) |=> layout == LAYOUT_RSVD;
  endproperty
  a_layout_rsvd: assert property (p_layout_rsvd)
    else $error("reserved mode not mapped to reserved layout");

  property p_layout_gbic;
    @(posedge clk_in) disable iff (rst_in)
      (mode_sync == `MODE_GBIC) |=> layout == LAYOUT_GBIC;
  endproperty
  a_layout_gbic: assert property (p_layout_gbic)
    else $error("gbic mode not mapped to partner layout");

  c_commit:   cover property (@(posedge clk_in) pend_valid_reg && ev.restart);
  c_linkdown: cover property (@(posedge clk_in) ev.link_down && pend_valid_reg);
  c_gbic:     cover property (@(posedge clk_in) req.rd && layout == LAYOUT_GBIC);
  c_copper:   cover property (@(posedge clk_in) req.rd && layout == LAYOUT_SGMII_CU);
  c_power:    cover property (@(posedge clk_in) ev.power_up && pend_valid_reg);

endmodule // fiber_aneg_advert

/* File: test_fiber_aneg_advert.sv */
module test_fiber_aneg_advert
  import fiber_aneg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in, rst_in, wr_in, rd_in;
  logic [3:0]  addr_in, autoneg_strap_config_in, hw_mode_in;
  logic [15:0] wdata_in, rdata_out, d;
  logic        link_up_in, full_duplex_in, lp_half_in, lp_full_in, irq_out;
  logic [1:0]  speed_in, lp_pause_in, advert_out, m_act, m_pend;
  int          n_mismatch, n_checks, seed, v, m_fiber;

  fiber_aneg_advert dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .autoneg_strap_config_in(autoneg_strap_config_in),
    .hw_mode_in(hw_mode_in), .link_up_in(link_up_in), .full_duplex_in(full_duplex_in),
    .speed_in(speed_in), .lp_pause_in(lp_pause_in), .lp_half_in(lp_half_in),
    .lp_full_in(lp_full_in), .rdata_out(rdata_out), .advert_out(advert_out),
    .irq_out(irq_out)
  );

  // Free-running 100 MHz clock
  always #5 clk_in = ~clk_in;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Write cycle; the model holds advert writes pending in fiber layout only
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= w;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    if (a == 4'h4 && m_fiber != 0) m_pend = w[6:5];
    if (a == 4'h0 && (w[15] || w[9])) m_act = m_pend;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] r);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 r = rdata_out;
  endtask

  task automatic hw_reset(input logic [3:0] s);
    @(posedge clk_in);
    rst_in <= 1'b1;
    autoneg_strap_config_in <= s;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    m_act = {s[2], s[3]};
    m_pend = m_act;
  endtask

  task automatic set_mode(input logic [3:0] m);
    @(posedge clk_in);
    hw_mode_in <= m;
    m_fiber = (m != 4'h0 && m != 4'h8 && m[2:0] != 3'h6);
    wait_clk(6);
  endtask

  // Watchdog sized well beyond the few hundred cycles the tests take
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    logic [3:0] straps [4];
    straps = '{4'h4, 4'h8, 4'h0, 4'hC};
    clk_in = 0; rst_in = 1; wr_in = 0; rd_in = 0; addr_in = 0; wdata_in = 0;
    autoneg_strap_config_in = 4'hC; hw_mode_in = 4'h1; m_fiber = 1;
    link_up_in = 0; full_duplex_in = 0; speed_in = 0; lp_pause_in = 0;
    lp_half_in = 0; lp_full_in = 0; seed = 32'h280FB17E;
    // Strap defaults over several hardware resets
    foreach (straps[i]) begin
      hw_reset(straps[i]);
      wait_clk(3);
      chk(advert_out, m_act);
      bus_rd(4'h4, d);
      chk(d, {9'h0, m_act, 5'h0});
    end
    $display("test strap_defaults done");
    // Pending write, commit by restart
    bus_wr(4'h4, {9'h0, 2'b00, d[4:0]});
    wait_clk(3);
    chk(advert_out, 2'b11);
    bus_wr(4'h0, 16'h0200);
    wait_clk(3);
    chk(advert_out, m_act);
    bus_rd(4'h4, d);
    chk(d, 16'h0000);
    // Commit by software reset; straps are not reloaded
    bus_wr(4'h4, 16'h0020);
    bus_wr(4'h0, 16'h8000);
    wait_clk(3);
    chk(advert_out, 2'b01);
    // Commit on leaving power down only
    bus_wr(4'h0, 16'h0800);
    bus_wr(4'h4, 16'h0040);
    wait_clk(3);
    chk(advert_out, 2'b01);
    bus_wr(4'h0, 16'h0000);
    m_act = m_pend;
    wait_clk(3);
    chk(advert_out, m_act);
    $display("test commit_events done");
    // Link down commits and raises an unmasked interrupt
    @(posedge clk_in);
    link_up_in <= 1'b1;
    wait_clk(6);
    bus_rd(4'h1, d);
    bus_wr(4'h2, 16'h0003);
    bus_wr(4'h4, 16'h0060);
    link_up_in <= 1'b0;
    m_act = m_pend;
    wait_clk(8);
    chk(advert_out, 2'b11);
    chk(irq_out, 1'b1);
    bus_rd(4'h1, d);
    chk(d, 16'h0003);
    wait_clk(2);
    chk(irq_out, 1'b0);
    // Masked event leaves the line low but still sets status
    bus_wr(4'h2, 16'h0000);
    bus_wr(4'h4, 16'h0000);
    bus_wr(4'h0, 16'h0200);
    wait_clk(3);
    chk(irq_out, 1'b0);
    chk(advert_out, 2'b00);
    bus_rd(4'h1, d);
    chk(d, 16'h0002);
    $display("test interrupt done");
    // Copper status view with random link and duplex levels, speed codes 0 to 2; writes have no effect
    set_mode(4'h0);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      @(posedge clk_in);
      link_up_in <= v[0];
      full_duplex_in <= v[1];
      speed_in <= 2'(i % 3);
      wait_clk(6);
      bus_rd(4'h4, d);
      chk(d, {v[0], 2'b00, v[1], 2'(i % 3), 10'h0});
    end
    bus_wr(4'h4, 16'h0060);
    bus_wr(4'h0, 16'h0200);
    wait_clk(3);
    chk(advert_out, 2'b00);
    $display("test copper_view done");
    // Partner ability view, every pause code
    set_mode(4'h8);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      @(posedge clk_in);
      lp_pause_in <= 2'(i);
      lp_half_in <= i[2];
      lp_full_in <= v[0];
      wait_clk(6);
      bus_rd(4'h4, d);
      chk(d, {7'h0, 2'(i), i[2], v[0], 5'h0});
    end
    $display("test partner_view done");
    // Reserved layout for both x110 codes, writes dropped
    set_mode(4'h6);
    bus_rd(4'h4, d);
    chk(d, 16'h0000);
    bus_wr(4'h4, 16'hFFFF);
    set_mode(4'hE);
    bus_rd(4'h4, d);
    chk(d, 16'h0000);
    set_mode(4'h1);
    bus_wr(4'h0, 16'h0200);
    wait_clk(3);
    chk(advert_out, m_act);
    bus_rd(4'h3, d);
    chk(d, 16'h0000);
    $display("test reserved_view done");
    stop_test();
  end
endmodule // test_fiber_aneg_advert
